// file: tag_slot_regs.svh
// Purpose: Constants for the tag slot anticollision logic.
// Assumes: Included by its bare name.
// Notes: Command codes arrive already decoded by the frame receiver.
`ifndef TAG_SLOT_REGS_SVH
`define TAG_SLOT_REGS_SVH

`define ID_WIDTH 8
`define SLOT_WIDTH 4
`define SLOT_ZERO 4'h0
`define ID_RESET 8'h00
`define LFSR_SEED 16'hACE1
`define LFSR_TAPS 16'hB400
`define CMD_WAKE 3'h1
`define CMD_POLL 3'h2
`define CMD_TICK 3'h3
`define CMD_SELECT 3'h4
`define CMD_COMPLETE 3'h5

`endif

// file: tag_slot_pkg.sv
// Purpose: Types for the tag slot anticollision logic.
// Assumes: Nothing beyond the constants header.
// Notes: State set follows the tag power states.
package tag_slot_pkg;

    typedef enum logic [2:0] {
        st_ready,
        st_inventory,
        st_selected,
        st_deselected,
        st_deactivated
    } tag_state_type;

    typedef struct packed {
        tag_state_type state;
        logic [15:0] lfsr;
        logic [7:0] tag_short_identifier;
        logic reply_valid;
        logic [7:0] reply_id;
    } tag_regs_type;

endpackage

// file: tag_slot_anticollision.sv
// Purpose: Slot-based anticollision state of a contactless tag.
// Assumes: cmd_valid pulses once per fully received frame, crc_ok qualifies it.
// Notes: Field power-up is sys_rst; all command inputs come from same-clock logic.
`timescale 1ns/1ns
`include "tag_slot_regs.svh"

module tag_slot_anticollision (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire logic crc_ok,
    input wire logic [2:0] cmd_code,
    input wire logic [7:0] cmd_arg,
    output logic reply_valid,
    output logic [7:0] reply_id,
    output logic [2:0] tag_state
);

    tag_slot_pkg::tag_regs_type cur_r;
    tag_slot_pkg::tag_regs_type cur_nxt;
    logic accept;
    logic [3:0] new_slot;
    logic [7:0] own_id;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        cur_nxt = cur_r;
        cur_nxt.reply_valid = 1'b0;
        // Galois LFSR free-runs every cycle, so draw time decorrelates tags
        cur_nxt.lfsr = cur_r.lfsr[0] ? ((cur_r.lfsr >> 1) ^ `LFSR_TAPS) : (cur_r.lfsr >> 1);
        accept = cmd_valid && crc_ok;
        new_slot = cur_r.lfsr[3:0];
        own_id = cur_r.tag_short_identifier;
        if (accept) begin
            case (cur_r.state)
                tag_slot_pkg::st_ready: begin
                    // Slot commands fall through here unanswered
                    if (cmd_code == `CMD_WAKE) begin
                        cur_nxt.tag_short_identifier = cur_r.lfsr[7:0];
                        cur_nxt.state = tag_slot_pkg::st_inventory;
                        cur_nxt.reply_valid = 1'b1;
                        cur_nxt.reply_id = cur_r.lfsr[7:0];
                    end
                end
                tag_slot_pkg::st_inventory: begin
                    if (cmd_code == `CMD_WAKE) begin
                        cur_nxt.tag_short_identifier = cur_r.lfsr[7:0];
                        cur_nxt.reply_valid = 1'b1;
                        cur_nxt.reply_id = cur_r.lfsr[7:0];
                    end else if (cmd_code == `CMD_POLL) begin
                        cur_nxt.tag_short_identifier = {own_id[7:4], new_slot};
                        if (new_slot == `SLOT_ZERO) begin
                            cur_nxt.reply_valid = 1'b1;
                            cur_nxt.reply_id = {own_id[7:4], new_slot};
                        end
                    end else if (cmd_code == `CMD_TICK) begin
                        // Parameter zero never matches: slot zero belongs to the poll
                        if (cmd_arg[3:0] != `SLOT_ZERO && cmd_arg[3:0] == own_id[3:0]) begin
                            cur_nxt.reply_valid = 1'b1;
                            cur_nxt.reply_id = own_id;
                        end
                    end else if (cmd_code == `CMD_SELECT && cmd_arg == own_id) begin
                        cur_nxt.state = tag_slot_pkg::st_selected;
                        cur_nxt.reply_valid = 1'b1;
                        cur_nxt.reply_id = own_id;
                    end
                end
                tag_slot_pkg::st_selected: begin
                    if (cmd_code == `CMD_SELECT) begin
                        cur_nxt.state = (cmd_arg == own_id) ? tag_slot_pkg::st_selected
                                                            : tag_slot_pkg::st_deselected;
                        cur_nxt.reply_valid = (cmd_arg == own_id);
                        cur_nxt.reply_id = own_id;
                    end else if (cmd_code == `CMD_COMPLETE) begin
                        cur_nxt.state = tag_slot_pkg::st_deactivated;
                    end
                end
                tag_slot_pkg::st_deselected: begin
                    if (cmd_code == `CMD_SELECT && cmd_arg == own_id) begin
                        cur_nxt.state = tag_slot_pkg::st_selected;
                        cur_nxt.reply_valid = 1'b1;
                        cur_nxt.reply_id = own_id;
                    end
                end
                default: begin
                    cur_nxt.state = cur_r.state;
                end
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cur_r <= '{state: tag_slot_pkg::st_ready, lfsr: `LFSR_SEED,
                       tag_short_identifier: `ID_RESET, reply_valid: 1'b0, reply_id: `ID_RESET};
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign reply_valid = cur_r.reply_valid;
    assign reply_id = cur_r.reply_id;
    assign tag_state = cur_r.state;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    poll_draws_slot_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cmd_valid && crc_ok && cmd_code == `CMD_POLL && cur_r.state == tag_slot_pkg::st_inventory)
        |=> cur_r.tag_short_identifier[3:0] == $past(cur_r.lfsr[3:0]))
        else $error("slot index not reloaded on poll");
    poll_zero_reply_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cmd_valid && crc_ok && cmd_code == `CMD_POLL && cur_r.state == tag_slot_pkg::st_inventory)
        |=> reply_valid == (cur_r.tag_short_identifier[3:0] == 4'h0))
        else $error("poll reply does not follow slot zero");
    poll_reply_id_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cmd_valid && crc_ok && cmd_code == `CMD_POLL && cur_r.state == tag_slot_pkg::st_inventory)
        ##1 reply_valid |-> reply_id == cur_r.tag_short_identifier)
        else $error("poll reply carries wrong identifier");
    tick_match_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cmd_valid && crc_ok && cmd_code == `CMD_TICK && cur_r.state == tag_slot_pkg::st_inventory
         && cmd_arg[3:0] != 4'h0)
        |=> reply_valid == ($past(cmd_arg[3:0]) == cur_r.tag_short_identifier[3:0]))
        else $error("slot tick reply mismatch");
    slot_outside_inv_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cmd_valid && (cmd_code == `CMD_POLL || cmd_code == `CMD_TICK)
         && cur_r.state != tag_slot_pkg::st_inventory)
        |=> !reply_valid && $stable(cur_r.tag_short_identifier))
        else $error("slot command answered outside inventory");
    ready_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cur_r.state == tag_slot_pkg::st_ready && !(cmd_valid && crc_ok && cmd_code == `CMD_WAKE))
        |=> cur_r.state == tag_slot_pkg::st_ready)
        else $error("ready state left without wake");
    wake_enters_inv_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cmd_valid && crc_ok && cmd_code == `CMD_WAKE && cur_r.state == tag_slot_pkg::st_ready)
        |=> cur_r.state == tag_slot_pkg::st_inventory && reply_id == $past(cur_r.lfsr[7:0]))
        else $error("wake did not enter inventory");
    select_match_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cmd_valid && crc_ok && cmd_code == `CMD_SELECT && cur_r.state == tag_slot_pkg::st_inventory)
        |=> (cur_r.state == tag_slot_pkg::st_selected) == ($past(cmd_arg) == $past(cur_r.tag_short_identifier)))
        else $error("select transition wrong");
    crc_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        !(cmd_valid && crc_ok) |=> !reply_valid && $stable(cur_r.state))
        else $error("reply without checked frame");

    // ----------------------------------------
    // Reply, identity, state and generator checks
    // ----------------------------------------
    poll_zero_id_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cmd_valid && crc_ok && cmd_code == `CMD_POLL && cur_r.state == tag_slot_pkg::st_inventory)
        ##1 reply_valid |-> reply_id[3:0] == `SLOT_ZERO)
        else $error("poll reply outside slot zero");
    tick_zero_silent_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cmd_valid && crc_ok && cmd_code == `CMD_TICK && cmd_arg[3:0] == `SLOT_ZERO)
        |=> !reply_valid)
        else $error("slot tick zero answered");
    tick_reply_id_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cmd_valid && crc_ok && cmd_code == `CMD_TICK && cur_r.state == tag_slot_pkg::st_inventory)
        ##1 reply_valid |-> reply_id == cur_r.tag_short_identifier && reply_id[3:0] == $past(cmd_arg[3:0]))
        else $error("slot tick reply carries wrong identifier");
    tick_keeps_id_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cmd_valid && crc_ok && cmd_code == `CMD_TICK)
        |=> $stable(cur_r.tag_short_identifier) && $stable(cur_r.state))
        else $error("slot tick changed identifier or state");
    slot_upper_kept_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cmd_valid && crc_ok && cmd_code == `CMD_POLL && cur_r.state == tag_slot_pkg::st_inventory)
        |=> cur_r.tag_short_identifier[7:4] == $past(cur_r.tag_short_identifier[7:4]))
        else $error("poll disturbed upper identifier bits");
    slot_cmd_stays_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cmd_valid && crc_ok && (cmd_code == `CMD_POLL || cmd_code == `CMD_TICK)
         && cur_r.state == tag_slot_pkg::st_inventory)
        |=> cur_r.state == tag_slot_pkg::st_inventory)
        else $error("slot command left inventory");
    ready_silent_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cmd_valid && cur_r.state == tag_slot_pkg::st_ready && cmd_code != `CMD_WAKE)
        |=> !reply_valid && cur_r.state == tag_slot_pkg::st_ready)
        else $error("ready tag answered before wake");
    wake_redraw_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cmd_valid && crc_ok && cmd_code == `CMD_WAKE && cur_r.state == tag_slot_pkg::st_inventory)
        |=> cur_r.state == tag_slot_pkg::st_inventory && reply_valid
            && cur_r.tag_short_identifier == $past(cur_r.lfsr[7:0]))
        else $error("wake in inventory did not redraw identifier");
    select_reply_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cmd_valid && crc_ok && cmd_code == `CMD_SELECT && cur_r.state == tag_slot_pkg::st_inventory)
        |=> reply_valid == ($past(cmd_arg) == $past(cur_r.tag_short_identifier))
            && (!reply_valid || reply_id == $past(cmd_arg)))
        else $error("select reply wrong");
    // A stuck generator would hand every tag the same slot
    lfsr_alive_a: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> cur_r.lfsr != 16'h0000 && cur_r.lfsr != $past(cur_r.lfsr))
        else $error("random generator stalled");
    reply_needs_frame_a: assert property (@(posedge clk) disable iff (sys_rst)
        reply_valid |-> $past(cmd_valid && crc_ok))
        else $error("reply without an accepted frame");
    // Identifier holds between replies, so the sender may read it late
    reply_id_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        !reply_valid |-> $stable(reply_id))
        else $error("identifier changed without a reply");

endmodule

// file: slot_reader_model.sv
// Purpose: Reader side that hands decoded command frames to the tag.
// Assumes: Commands change on the falling edge, one frame per issue call.
// Notes: Idle crc_ok and cmd_arg invert (cmd_code holds) so a stale argument is never mistaken for a live one.
`timescale 1ns/1ns

module slot_reader_model (
    input wire logic clk,
    output logic cmd_valid,
    output logic crc_ok,
    output logic [2:0] cmd_code,
    output logic [7:0] cmd_arg
);
    initial begin
        cmd_valid = 1'b0;
        crc_ok = 1'b0;
        cmd_code = 3'h0;
        cmd_arg = 8'h5A;
    end
    // -----------------------------
    // One frame, held a full cycle
    // -----------------------------
    task automatic issue(input logic [2:0] code, input logic [7:0] arg, input logic crc);
        @(negedge clk);
        cmd_valid = 1'b1;
        crc_ok = crc;
        cmd_code = code;
        cmd_arg = arg;
        @(negedge clk);
        cmd_valid = 1'b0;
        crc_ok = ~crc;
        cmd_arg = ~arg;
    endtask
endmodule

// file: tag_slot_anticollision_test.sv
// Purpose: Self-checking bench for the tag slot anticollision logic.
// Assumes: Replies show at the taking edge and are checked on the next falling edge.
// Notes: Random identifiers are unknown, so checks use their consistency.
`timescale 1ns/1ns
`include "tag_slot_regs.svh"

module tag_slot_anticollision_test;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid, crc_ok, reply_valid;
    logic [2:0] cmd_code, tag_state;
    logic [7:0] cmd_arg, reply_id, id_r;
    int bad_count = 0;
    int n_tests = 0;
    int hits;
    always #10 clk = ~clk;
    slot_reader_model rdr (.clk(clk), .cmd_valid(cmd_valid), .crc_ok(crc_ok),
        .cmd_code(cmd_code), .cmd_arg(cmd_arg));
    tag_slot_anticollision dut (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .crc_ok(crc_ok),
        .cmd_code(cmd_code), .cmd_arg(cmd_arg), .reply_valid(reply_valid), .reply_id(reply_id),
        .tag_state(tag_state));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] st(input tag_slot_pkg::tag_state_type s);
        return {5'h00, 3'(s)};
    endfunction
    // -----------------------------
    // Scenarios
    // -----------------------------
    task automatic test_ready;
        rdr.issue(`CMD_POLL, 8'h00, 1'b1);
        check("reply_valid", 8'h00, {7'h00, reply_valid});
        rdr.issue(`CMD_TICK, 8'h01, 1'b1);
        check("reply_valid", 8'h00, {7'h00, reply_valid});
        rdr.issue(`CMD_WAKE, 8'h00, 1'b0);
        check("tag_state", st(tag_slot_pkg::st_ready), {5'h00, tag_state});
        $display("test ready done");
    endtask
    task automatic test_wake;
        rdr.issue(`CMD_WAKE, 8'h00, 1'b1);
        check("tag_state", st(tag_slot_pkg::st_inventory), {5'h00, tag_state});
        check("reply_valid", 8'h01, {7'h00, reply_valid});
        rdr.issue(`CMD_WAKE, 8'h00, 1'b1);
        check("tag_state", st(tag_slot_pkg::st_inventory), {5'h00, tag_state});
        check("reply_valid", 8'h01, {7'h00, reply_valid});
        id_r = reply_id;
        $display("test wake done");
    endtask
    task automatic test_slots;
        rdr.issue(`CMD_POLL, 8'h00, 1'b0);
        check("reply_valid", 8'h00, {7'h00, reply_valid});
        rdr.issue(`CMD_POLL, 8'h00, 1'b1);
        hits = int'(reply_valid === 1'b1);
        if (reply_valid === 1'b1) begin
            check("poll id", {id_r[7:4], 4'h0}, reply_id);
            id_r = reply_id;
        end
        rdr.issue(`CMD_TICK, 8'h00, 1'b1);
        check("reply_valid", 8'h00, {7'h00, reply_valid});
        for (int n = 1; n <= 15; n++) begin
            rdr.issue(`CMD_TICK, 8'(n), 1'b1);
            if (reply_valid === 1'b1) begin
                hits++;
                check("tick id", {id_r[7:4], 4'(n)}, reply_id);
                id_r = reply_id;
            end
        end
        check("slot hits", 8'h01, 8'(hits));
        $display("test slots done");
    endtask
    task automatic test_select;
        rdr.issue(`CMD_SELECT, ~id_r, 1'b1);
        check("tag_state", st(tag_slot_pkg::st_inventory), {5'h00, tag_state});
        rdr.issue(`CMD_SELECT, id_r, 1'b1);
        check("tag_state", st(tag_slot_pkg::st_selected), {5'h00, tag_state});
        check("select id", id_r, reply_id);
        rdr.issue(`CMD_POLL, 8'h00, 1'b1);
        check("reply_valid", 8'h00, {7'h00, reply_valid});
        $display("test select done");
    endtask
    task automatic test_release;
        rdr.issue(`CMD_SELECT, ~id_r, 1'b1);
        check("tag_state", st(tag_slot_pkg::st_deselected), {5'h00, tag_state});
        check("reply_valid", 8'h00, {7'h00, reply_valid});
        rdr.issue(`CMD_TICK, {4'h0, id_r[3:0]}, 1'b1);
        check("reply_valid", 8'h00, {7'h00, reply_valid});
        rdr.issue(`CMD_SELECT, id_r, 1'b1);
        check("tag_state", st(tag_slot_pkg::st_selected), {5'h00, tag_state});
        check("reply_valid", 8'h01, {7'h00, reply_valid});
        check("select id", id_r, reply_id);
        rdr.issue(`CMD_COMPLETE, 8'h00, 1'b1);
        check("tag_state", st(tag_slot_pkg::st_deactivated), {5'h00, tag_state});
        rdr.issue(`CMD_WAKE, 8'h00, 1'b1);
        check("tag_state", st(tag_slot_pkg::st_deactivated), {5'h00, tag_state});
        check("reply_valid", 8'h00, {7'h00, reply_valid});
        $display("test release done");
    endtask
    task automatic test_power_up;
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        check("tag_state", st(tag_slot_pkg::st_ready), {5'h00, tag_state});
        check("reply_id", `ID_RESET, reply_id);
        rdr.issue(`CMD_POLL, 8'h00, 1'b1);
        check("reply_valid", 8'h00, {7'h00, reply_valid});
        check("tag_state", st(tag_slot_pkg::st_ready), {5'h00, tag_state});
        rdr.issue(`CMD_WAKE, 8'h00, 1'b1);
        check("tag_state", st(tag_slot_pkg::st_inventory), {5'h00, tag_state});
        check("reply_valid", 8'h01, {7'h00, reply_valid});
        $display("test power up done");
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        test_ready();
        test_wake();
        test_slots();
        test_select();
        test_release();
        test_power_up();
        close_out();
    end
endmodule
